// *** rtl/tw_host_master.sv ***
`timescale 1ns/1ps
module tw_host_master import tw_pkg::*; #(
    parameter int HALF_CYC = SCL_HALF_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Command port
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_op,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_last,
    output logic cmd_ready,
    // Answer port
    output logic resp_valid,
    output logic [7:0] resp_data,
    output logic resp_ack,
    output logic resp_err,
    // Bus state
    input wire logic force_idle,
    output logic [1:0] bus_state,
    // Open-drain SCL
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    // Open-drain SDA
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);

    localparam logic [TMR_W-1:0] HALF_M1 = TMR_W'(HALF_CYC - 1);

    // ------------------------------------------------------------
    // Line monitor
    // ------------------------------------------------------------
    logic scl_s;
    logic sda_s;
    logic start_det;
    logic stop_det;

    tw_line_mon u_mon (
        .ref_clk(ref_clk),
        .rst(rst),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .scl_s(scl_s),
        .sda_s(sda_s),
        .start_det(start_det),
        .stop_det(stop_det)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    tw_state_t st;
    tw_bus_t bus;
    logic [1:0] ph;
    logic [TMR_W-1:0] tmr;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic own;
    logic rd_dir;
    logic addr_phase;
    logic last;
    logic is_rd;
    logic stop_resp;

    // Lines are only ever pulled low, never driven high
    assign scl_o = 1'b0; // R7
    assign sda_o = 1'b0; // R7
    assign bus_state = bus;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // SCL is released in phase 1 of every state, also in Start phase 2 and Stop phase 3
    wire wait_high = (st != ST_IDLE) && (ph == 2'h1);
    wire tmr_zero = (tmr == '0);
    // Count high time only once SCL is really high, so stretching holds us
    wire tmr_run = !wait_high || scl_s; // R21
    wire step = tmr_zero && tmr_run;
    wire take = cmd_valid && cmd_ready;
    wire busy_ext = (bus != BUS_IDLE);
    wire bad_start = !own && busy_ext; // R4
    wire bad_dir = (cmd_op == OP_WRITE && rd_dir) || (cmd_op == OP_READ && !rd_dir); // R16
    wire refuse = (cmd_op == OP_START) ? bad_start : (!own || bad_dir);
    wire last_bit = (bit_cnt == ACK_BIT_IDX);
    wire byte_done = (st == ST_BIT) && (ph == 2'h1) && step && last_bit;
    // Writer sees released SDA as not-acknowledge; reader ends after last byte
    wire auto_stop = is_rd ? last : sda_s; // R18 R19
    // SDA pull-down enable for the coming SCL high phase (1 sends a 0 bit)
    wire next_sda_drv = last_bit ? (is_rd && !last) : (!is_rd && !shreg[7]); // R13 R19

    // ------------------------------------------------------------
    // Half-period timer
    // ------------------------------------------------------------
    // Reloads at every phase step, frozen while a stretched SCL stays low
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tmr <= '0;
        end else if (st == ST_IDLE || step) begin
            tmr <= HALF_M1;
        end else if (tmr_run) begin
            tmr <= tmr - 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Bus state tracking
    // ------------------------------------------------------------
    // Foreign Starts on an idle bus mark it busy; any Stop frees it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus <= BUS_UNKNOWN; // R23
        end else if (own) begin
            bus <= BUS_OWNER;
        end else if (bus == BUS_OWNER || stop_det) begin
            bus <= BUS_IDLE; // R5
        end else if (force_idle && bus == BUS_UNKNOWN) begin
            bus <= BUS_IDLE; // R4
        end else if (start_det && bus == BUS_IDLE && st != ST_START) begin
            bus <= BUS_BUSY;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Device setup writes are ordinary command sequences in caller order: R1 R3 R6
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= ST_IDLE;
            ph <= 2'h0;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            own <= 1'b0;
            rd_dir <= 1'b0;
            addr_phase <= 1'b0;
            last <= 1'b0;
            is_rd <= 1'b0;
            stop_resp <= 1'b0;
            scl_oe <= 1'b0; // R23
            sda_oe <= 1'b0; // R23
            cmd_ready <= 1'b0;
            resp_valid <= 1'b0;
            resp_data <= 8'h00;
            resp_ack <= 1'b0;
            resp_err <= 1'b0;
        end else begin
            resp_valid <= 1'b0;
            case (st)
                ST_IDLE: begin
                    cmd_ready <= !take;
                    if (take && refuse) begin
                        resp_valid <= 1'b1;
                        resp_err <= 1'b1;
                        resp_ack <= 1'b0;
                    end else if (take) begin
                        resp_err <= 1'b0;
                        last <= cmd_last;
                        bit_cnt <= 4'h0;
                        stop_resp <= 1'b0;
                        case (cmd_op)
                            OP_START: begin
                                // Repeated Start if we still own the bus
                                st <= ST_START; // R10 R20
                                ph <= 2'h0;
                                sda_oe <= 1'b0;
                                shreg <= cmd_data; // R14
                                rd_dir <= cmd_data[DIR_BIT_POS]; // R16
                                addr_phase <= 1'b1; // R15
                                is_rd <= 1'b0;
                            end
                            OP_WRITE: begin
                                st <= ST_BIT;
                                ph <= 2'h2;
                                shreg <= cmd_data;
                                addr_phase <= 1'b0;
                                is_rd <= 1'b0;
                            end
                            OP_READ: begin
                                st <= ST_BIT;
                                ph <= 2'h2;
                                shreg <= 8'h00;
                                addr_phase <= 1'b0;
                                is_rd <= 1'b1;
                            end
                            default: begin
                                // Allowed straight after the address packet
                                st <= ST_STOP; // R17
                                ph <= 2'h0;
                                stop_resp <= 1'b1;
                            end
                        endcase
                    end
                end
                ST_START: begin
                    if (step) begin
                        case (ph)
                            2'h0: begin
                                scl_oe <= 1'b0;
                                ph <= 2'h1;
                            end
                            2'h1: begin
                                sda_oe <= 1'b1; // R9
                                ph <= 2'h2;
                            end
                            default: begin
                                scl_oe <= 1'b1;
                                own <= 1'b1;
                                st <= ST_BIT;
                                ph <= 2'h2;
                            end
                        endcase
                    end
                end
                ST_BIT: begin
                    if (step) begin
                        case (ph)
                            2'h0: begin
                                scl_oe <= 1'b0;
                                ph <= 2'h1;
                            end
                            2'h1: begin
                                scl_oe <= 1'b1;
                                if (last_bit) begin
                                    resp_valid <= 1'b1;
                                    resp_data <= shreg;
                                    resp_ack <= !sda_s; // R13
                                    addr_phase <= 1'b0;
                                    st <= auto_stop ? ST_STOP : ST_IDLE; // R18
                                    ph <= 2'h0;
                                end else begin
                                    shreg <= {shreg[6:0], sda_s}; // R12
                                    bit_cnt <= bit_cnt + 4'h1; // R12
                                    ph <= 2'h2;
                                end
                            end
                            default: begin
                                // SCL has been low for a half period here
                                sda_oe <= next_sda_drv; // R11
                                ph <= 2'h0;
                            end
                        endcase
                    end
                end
                ST_STOP: begin
                    if (step) begin
                        case (ph)
                            2'h0: begin
                                sda_oe <= 1'b1;
                                ph <= 2'h2;
                            end
                            2'h2: begin
                                scl_oe <= 1'b0;
                                ph <= 2'h1;
                            end
                            2'h1: begin
                                sda_oe <= 1'b0; // R9
                                ph <= 2'h3;
                            end
                            default: begin
                                own <= 1'b0;
                                resp_valid <= stop_resp;
                                resp_ack <= 1'b0;
                                st <= ST_IDLE;
                                ph <= 2'h0;
                            end
                        endcase
                    end
                end
                default: begin
                    st <= ST_IDLE;
                    ph <= 2'h0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_sda_low_only: assert property (@(posedge ref_clk) disable iff (rst) // R11
        (st == ST_BIT && $changed(sda_oe)) |-> scl_oe && $past(scl_oe))
        else $error("SDA moved while SCL was released during a bit");

    a_start_shape: assert property (@(posedge ref_clk) disable iff (rst) // R9
        ($rose(sda_oe) && !scl_oe) |-> st == ST_START)
        else $error("SDA pulled under high SCL outside a Start");

    a_stop_shape: assert property (@(posedge ref_clk) disable iff (rst) // R9
        ($fell(sda_oe) && !scl_oe) |-> st == ST_STOP)
        else $error("SDA released under high SCL outside a Stop");

    a_nine_bits: assert property (@(posedge ref_clk) disable iff (rst) // R12
        (st == ST_BIT && ph == 2'h1 && step && !last_bit) |=>
        st == ST_BIT && bit_cnt == $past(bit_cnt) + 4'h1)
        else $error("byte did not span nine clocks");

    a_read_ack: assert property (@(posedge ref_clk) disable iff (rst) // R19
        (st == ST_BIT && is_rd && last_bit && ph == 2'h1) |-> sda_oe == !last)
        else $error("wrong acknowledge driven on read");

    a_nack_stop: assert property (@(posedge ref_clk) disable iff (rst) // R18
        (byte_done && !is_rd && sda_s) |=> st == ST_STOP ##1 (st == ST_STOP)[*2])
        else $error("no Stop after a refused write byte");

    a_stretch_wait: assert property (@(posedge ref_clk) disable iff (rst) // R21
        (st == ST_BIT && ph == 2'h1 && !scl_s) |=> tmr == $past(tmr) && scl_oe == 1'b0)
        else $error("high time counted while SCL held low");

    a_addr_first: assert property (@(posedge ref_clk) disable iff (rst) // R15
        (st == ST_START ##1 st == ST_BIT) |-> addr_phase && !is_rd)
        else $error("Start not followed by an address packet");

    a_start_idle: assert property (@(posedge ref_clk) disable iff (rst) // R4
        (take && cmd_op == OP_START && !own && bus != BUS_IDLE) |=>
        st == ST_IDLE && resp_valid && resp_err)
        else $error("Start issued on a bus not known idle");

    a_read_release: assert property (@(posedge ref_clk) disable iff (rst) // R16
        (st == ST_BIT && is_rd && !last_bit && ph != 2'h2) |-> !sda_oe)
        else $error("master drove SDA during a read data bit");

endmodule

// *** rtl/tw_line_mon.sv ***
`timescale 1ns/1ps
module tw_line_mon import tw_pkg::*; (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Raw bus lines
    input wire logic scl_i,
    input wire logic sda_i,
    // Synchronised levels and conditions
    output logic scl_s,
    output logic sda_s,
    output logic start_det,
    output logic stop_det
);

    // ------------------------------------------------------------
    // Synchronisers and delayed copies
    // ------------------------------------------------------------
    logic scl_m;
    logic sda_m;
    logic scl_d;
    logic sda_d;

    // First stage feeds only the second; edge logic looks at later stages
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            scl_m <= LINE_IDLE_LEVEL;
            sda_m <= LINE_IDLE_LEVEL;
            scl_s <= LINE_IDLE_LEVEL;
            sda_s <= LINE_IDLE_LEVEL;
            scl_d <= LINE_IDLE_LEVEL;
            sda_d <= LINE_IDLE_LEVEL;
        end else begin
            scl_m <= scl_i;
            sda_m <= sda_i;
            scl_s <= scl_m;
            sda_s <= sda_m;
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // ------------------------------------------------------------
    // Start and Stop detection
    // ------------------------------------------------------------
    wire is_start = scl_s && scl_d && sda_d && !sda_s;
    wire is_stop = scl_s && scl_d && !sda_d && sda_s;

    // SDA edge while SCL held high on both samples
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            start_det <= 1'b0;
            stop_det <= 1'b0;
        end else begin
            start_det <= is_start; // R9
            stop_det <= is_stop; // R9
        end
    end

    a_start_seen: assert property (@(posedge ref_clk) disable iff (rst) // R9
        start_det |-> $past(scl_s) && $past(sda_d) && !$past(sda_s))
        else $error("start flagged without falling SDA under high SCL");

    a_stop_seen: assert property (@(posedge ref_clk) disable iff (rst) // R9
        (scl_s && scl_d && !sda_d && sda_s) |=> stop_det)
        else $error("stop condition missed");

endmodule

// *** rtl/tw_pkg.sv ***
// Function
// [R1] Software sets setup, hold and fast-plus timing before enabling master or slave.
// [R2] In dual mode master enables primary pins; secondary enable bit drives slave pins.
// [R3] Software should program the master bit-rate divider before enabling the master.
// [R4] Without timeout, software forces bus state idle by writing 0x1.
// [R5] The bus monitor treats the bus as idle after any Stop.
// [R6] Slave starts after own address written and slave enable set.
// [R7] Parties only pull lines low or release them; pull-ups give high.
// [R8] Device may hold master and slave and answer several addresses.
// [R9] Start is SDA falling with SCL high; Stop is SDA rising with SCL high.
// [R10] A Start not directly after a Stop counts as repeated Start.
// [R11] SDA stays stable while SCL is high and changes only while low.
// [R12] Each packet is eight bits MSB first plus one acknowledge bit.
// [R13] Receiver acknowledges by holding SDA low in the ninth clock.
// [R14] After Start the master sends a 7-bit address and direction bit.
// [R15] Exactly one address packet follows every Start or repeated Start.
// [R16] Direction 0 means master writes; direction 1 means slave sends data.
// [R17] With no data to send, master issues Stop right after the address.
// [R18] On a data not-acknowledge in a write, the master ends the transaction.
// [R19] Master reader acknowledges bytes it wants, not-acknowledges the final one.
// [R20] Combined transactions join segments with repeated Starts and no Stop.
// [R21] Any party may hold SCL low; the other side waits meanwhile.
// [R22] The device as slave stretches only just before or after acknowledge.
// [R23] Logic runs on one clock with synchronised pins; reset releases both lines.
package tw_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int SCL_HALF_NS = 5000;
    // Least time, so round up to whole cycles
    localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W = 12;

    // ------------------------------------------------------------
    // Packet layout
    // ------------------------------------------------------------
    localparam logic [3:0] ACK_BIT_IDX = 4'h8;
    localparam int DIR_BIT_POS = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic LINE_IDLE_LEVEL = 1'b1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BUS_UNKNOWN = 2'h0,
        BUS_IDLE = 2'h1,
        BUS_OWNER = 2'h2,
        BUS_BUSY = 2'h3
    } tw_bus_t;

    typedef enum logic [1:0] {
        OP_START = 2'h0,
        OP_WRITE = 2'h1,
        OP_READ = 2'h2,
        OP_STOP = 2'h3
    } tw_op_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_START = 4'h2,
        ST_BIT = 4'h4,
        ST_STOP = 4'h8
    } tw_state_t;

endpackage

// *** tb/tw_slave_model.sv ***
`timescale 1ns/1ps
module tw_slave_model #(
    parameter logic [6:0] OWN_ADDR = 7'h2a,
    parameter logic [6:0] ALT_ADDR = 7'h31,
    parameter logic [7:0] RD_FIRST = 8'hc3,
    parameter int WR_LIMIT = 2,
    parameter int HOLD_NS = 100,
    parameter int STRETCH_NS = 3000
) (
    // Resolved bus lines
    input wire logic scl,
    input wire logic sda,
    // Test control
    input wire logic stretch,
    // Open-drain pulls, high means pulling low
    output logic scl_pull,
    output logic sda_pull,
    // Last byte taken in a write
    output logic [7:0] got_byte
);
    // ------------------------------------------------------------
    // Behavioural slave, never drives a line high
    // ------------------------------------------------------------
    int bitn = 0;
    int wr_cnt = 0;
    logic [7:0] sh = 8'h00;
    logic [7:0] tx = 8'h00;
    logic in_addr = 1'b0;
    logic act = 1'b0;
    logic rd = 1'b0;
    logic macked = 1'b0;

    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
        got_byte = 8'h00;
    end

    // Start or repeated start restarts the address phase
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            bitn = 0;
            in_addr = 1'b1;
            act = 1'b0;
            sda_pull <= 1'b0;
        end
    end

    // Stop leaves the model waiting for the next start
    always @(posedge sda) begin
        if (scl === 1'b1) begin
            in_addr = 1'b0;
            act = 1'b0;
        end
    end

    // Sample on rising clock, first bit is the MSB
    always @(posedge scl) begin
        if (bitn < 8)
            sh = {sh[6:0], sda};
        else
            macked = !sda;
        bitn = bitn + 1;
    end

    // Change data only after the clock has fallen, with hold margin
    always @(negedge scl) begin
        if (bitn == 8) begin
            if (in_addr) begin
                act = (sh[7:1] == OWN_ADDR) || (sh[7:1] == ALT_ADDR);
                rd = sh[0];
                wr_cnt = 0;
            end else if (act && !rd) begin
                got_byte <= sh;
                wr_cnt = wr_cnt + 1;
            end
            sda_pull <= #HOLD_NS act && (in_addr || (!rd && wr_cnt <= WR_LIMIT));
        end else if (bitn == 9) begin
            bitn = 0;
            if (act && rd && (in_addr || macked)) begin
                tx = in_addr ? RD_FIRST : tx + 8'h01;
                sda_pull <= #HOLD_NS !tx[7];
            end else
                sda_pull <= #HOLD_NS 1'b0;
            in_addr = 1'b0;
            // Stretch only right after the acknowledge bit
            if (stretch && act) begin
                scl_pull <= 1'b1;
                scl_pull <= #STRETCH_NS 1'b0;
            end
        end else if (bitn > 0 && act && rd && !in_addr)
            sda_pull <= #HOLD_NS !tx[7 - bitn];
    end
endmodule

// *** tb/two_wire_bus_master_slave_bench.sv ***
`timescale 1ns/1ps
module two_wire_bus_master_slave_bench;
    import tw_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] op;
        logic [7:0] data;
        logic last;
        logic ack;
        logic [7:0] rdata;
        logic err;
        logic [1:0] st;
    } tw_row_t;
    logic ref_clk, rst, cmd_valid, cmd_last, cmd_ready, force_idle, stretch, ext_pull;
    logic [1:0] cmd_op, bus_state;
    logic [7:0] cmd_data, resp_data, got_byte;
    logic resp_valid, resp_ack, resp_err, scl_oe, sda_oe, scl_pull, sda_pull;
    wire logic scl;
    wire logic sda;
    int bad_count = 0;
    int cmp_count = 0;
    int n_start = 0;
    int n_stop = 0;
    int exp_start = 0;
    int exp_stop = 0;
    int lat_n, lat_s;
    // Slave answers 0x2a and 0x31; 0x10 is nobody
    tw_row_t rows [0:17] = '{
        '{OP_START, 8'h54, 1'h0, 1'h1, 8'h54, 1'h0, 2'h2},
        '{OP_WRITE, 8'h81, 1'h0, 1'h1, 8'h81, 1'h0, 2'h2},
        '{OP_WRITE, 8'h3c, 1'h0, 1'h1, 8'h3c, 1'h0, 2'h2},
        '{OP_READ, 8'h00, 1'h0, 1'h0, 8'h00, 1'h1, 2'h2},
        '{OP_START, 8'h55, 1'h0, 1'h1, 8'h55, 1'h0, 2'h2},
        '{OP_WRITE, 8'h99, 1'h0, 1'h0, 8'h00, 1'h1, 2'h2},
        '{OP_READ, 8'h00, 1'h0, 1'h1, 8'hc3, 1'h0, 2'h2},
        '{OP_READ, 8'h00, 1'h1, 1'h0, 8'hc4, 1'h0, 2'h2},
        '{OP_START, 8'h62, 1'h0, 1'h1, 8'h62, 1'h0, 2'h2},
        '{OP_STOP, 8'h00, 1'h0, 1'h0, 8'h00, 1'h0, 2'h1},
        '{OP_START, 8'h20, 1'h0, 1'h0, 8'h20, 1'h0, 2'h2},
        '{OP_WRITE, 8'h11, 1'h0, 1'h0, 8'h00, 1'h1, 2'h1},
        '{OP_START, 8'h54, 1'h0, 1'h1, 8'h54, 1'h0, 2'h2},
        '{OP_WRITE, 8'h11, 1'h0, 1'h1, 8'h11, 1'h0, 2'h2},
        '{OP_WRITE, 8'h22, 1'h0, 1'h1, 8'h22, 1'h0, 2'h2},
        '{OP_WRITE, 8'h33, 1'h0, 1'h0, 8'h33, 1'h0, 2'h2},
        '{OP_STOP, 8'h00, 1'h0, 1'h0, 8'h00, 1'h1, 2'h1},
        '{OP_READ, 8'h00, 1'h1, 1'h0, 8'h00, 1'h1, 2'h1}
    };

    // Pull-ups win unless someone pulls low
    assign scl = (scl_oe || scl_pull) ? 1'b0 : 1'b1;
    // ext_pull stands in for a foreign master on SDA
    assign sda = (sda_oe || sda_pull || ext_pull) ? 1'b0 : 1'b1;

    always #10 ref_clk = ~ref_clk;

    // Conditions seen on the wire
    always @(negedge sda) if (scl === 1'b1) n_start++;
    always @(posedge sda) if (scl === 1'b1) n_stop++;

    // Short half period keeps the run brief
    tw_host_master #(.HALF_CYC(6)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_data(cmd_data), .cmd_last(cmd_last), .cmd_ready(cmd_ready),
        .resp_valid(resp_valid), .resp_data(resp_data), .resp_ack(resp_ack),
        .resp_err(resp_err), .force_idle(force_idle), .bus_state(bus_state),
        .scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe)
    );
    tw_slave_model slv_u (
        .scl(scl), .sda(sda), .stretch(stretch), .scl_pull(scl_pull),
        .sda_pull(sda_pull), .got_byte(got_byte)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic close_out();
        if (bad_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Hold the command until taken, then wait for its answer
    task automatic run_cmd(input logic [1:0] op, input logic [7:0] d, input logic l,
                           output int lat);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 2000) begin
            @(negedge ref_clk);
            n++;
        end
        cmd_op = op;
        cmd_data = d;
        cmd_last = l;
        cmd_valid = 1'b1;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        lat = 0;
        while (resp_valid !== 1'b1 && lat < 2000) begin
            @(negedge ref_clk);
            lat++;
        end
        if (n >= 2000 || lat >= 2000) begin
            bad_count++;
            close_out();
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {ref_clk, rst, cmd_valid, cmd_last, force_idle, stretch, ext_pull} = 7'h20;
        cmd_op = OP_START;
        cmd_data = 8'h00;
        repeat (2) @(negedge ref_clk);
        check("oe in reset", {6'h00, scl_oe, sda_oe}, 8'h00);
        rst = 1'b0;
        @(negedge ref_clk);
        check("state unknown", {6'h00, bus_state}, {6'h00, BUS_UNKNOWN});
        check("ready", {7'h00, cmd_ready}, 8'h01);
        force_idle = 1'b1;
        @(negedge ref_clk);
        force_idle = 1'b0;
        @(negedge ref_clk);
        check("state forced", {6'h00, bus_state}, {6'h00, BUS_IDLE});
        {n_start, n_stop} = 64'h0;
        foreach (rows[i]) begin
            run_cmd(rows[i].op, rows[i].data, rows[i].last, lat_n);
            check("resp err", {7'h00, resp_err}, {7'h00, rows[i].err});
            check("resp ack", {7'h00, resp_ack}, {7'h00, rows[i].ack});
            if (!rows[i].err && rows[i].op != OP_STOP)
                check("resp data", resp_data, rows[i].rdata);
            @(negedge ref_clk);
            check("bus state", {6'h00, bus_state}, {6'h00, rows[i].st});
            if (rows[i].op == OP_WRITE && !rows[i].err)
                check("slave byte", got_byte, rows[i].data);
            exp_start += int'(rows[i].op == OP_START && !rows[i].err);
            exp_stop += int'(!rows[i].err && (rows[i].op == OP_STOP || !rows[i].ack));
        end
        // Slave holds the clock after the address acknowledge
        stretch = 1'b1;
        run_cmd(OP_START, 8'h54, 1'b0, lat_n);
        stretch = 1'b0;
        run_cmd(OP_WRITE, 8'h5a, 1'b0, lat_s);
        run_cmd(OP_WRITE, 8'h5b, 1'b0, lat_n);
        check("stretch wait", {7'h00, lat_s > lat_n + 100}, 8'h01);
        run_cmd(OP_STOP, 8'h00, 1'b0, lat_n);
        check("starts", 8'(n_start), 8'(exp_start + 1));
        check("stops", 8'(n_stop), 8'(exp_stop + 1));
        // A foreign Start keeps the bus busy until its Stop
        ext_pull = 1'b1;
        repeat (6) @(negedge ref_clk);
        run_cmd(OP_START, 8'h54, 1'b0, lat_n);
        check("busy refusal", {5'h00, resp_err, bus_state}, {5'h00, 1'b1, BUS_BUSY});
        ext_pull = 1'b0;
        repeat (8) @(negedge ref_clk);
        check("idle after stop", {6'h00, bus_state}, {6'h00, BUS_IDLE});
        // Reset in mid-transfer releases both lines
        run_cmd(OP_START, 8'h54, 1'b0, lat_n);
        cmd_op = OP_WRITE;
        cmd_valid = 1'b1;
        repeat (2) @(negedge ref_clk);
        cmd_valid = 1'b0;
        repeat (60) @(negedge ref_clk);
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        check("oe mid reset", {6'h00, scl_oe, sda_oe}, 8'h00);
        check("state mid reset", {6'h00, bus_state}, {6'h00, BUS_UNKNOWN});
        rst = 1'b0;
        // Bus state is unknown again, so a fresh Start is refused
        run_cmd(OP_START, 8'h54, 1'b0, lat_n);
        check("unknown refusal", {5'h00, resp_err, bus_state}, {5'h00, 1'b1, BUS_UNKNOWN});
        close_out();
    end
endmodule
